// *** watchdog_with_clock_protect.v ***
// Watchdog with 15-bit down-counter and count-source protection
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`include "wdt_regs.vh"

module watchdog_with_clock_protect (
  input  wire        clk,
  input  wire        rst,
  input  wire [15:0] addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output wire [15:0] rdata,
  input  wire [7:0]  option_byte_in,
  input  wire        option_erased,
  input  wire        subclock_input,
  input  wire        lowspeed_osc_clk,
  input  wire        cpu_stop_mode,
  input  wire        cpu_wait_mode,
  output wire        stop_mode_request,
  output wire        lowspeed_osc_stop,
  output wire        wdt_irq,
  output wire        wdt_reset
);
  reg        boot_done_ff;
  reg [7:0]  option_ff;
  reg        run_ff;
  reg [14:0] count_ff;
  reg [6:0]  prescale_ff;
  reg [4:0]  subdiv_ff;
  reg        refresh_armed_ff;
  reg        prescale_select_ff;
  reg        protection_enable_ff;
  reg        prot_zero_seen_ff;
  reg        source_select_ff;
  reg [1:0]  initial_count_select_ff;
  reg        underflow_reset_select_ff;
  reg        lowspeed_osc_stop_ff;
  reg        stop_mode_request_ff;
  reg        status_ff;
  reg        mask_ff;
  reg        wdt_reset_ff;
  reg [15:0] rdata_ff;

  reg [14:0] init_value;
  reg        count_tick;
  reg        halted;
  reg [15:0] nxt_rdata;

  wire       sub_edge;
  wire       losc_edge;
  wire       wr_refresh;
  wire       wr_start;
  wire       wr_protect;
  wire       refresh_ok;
  wire       prot_set;
  wire       cpu_tick;
  wire       sub_tick;
  wire       use_sub;
  wire       underflow;
  wire       count_en;
  wire [7:0] option_value;
  wire       wr_control;
  wire       wr_pmode1;
  wire       wr_cmode1;
  wire       wr_status;
  wire       wr_mask;

  tick_sync u_sub_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (subclock_input),
    .tick     (sub_edge)
  );

  tick_sync u_losc_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (lowspeed_osc_clk),
    .tick     (losc_edge)
  );

  assign wr_refresh = wr && (addr == `WDT_ADDR_REFRESH);
  assign wr_start   = wr && (addr == `WDT_ADDR_START);
  assign wr_protect = wr && (addr == `WDT_ADDR_PROTECT);
  assign wr_control = wr && (addr == `WDT_ADDR_CONTROL);
  assign wr_pmode1  = wr && (addr == `WDT_ADDR_PMODE1);
  assign wr_cmode1  = wr && (addr == `WDT_ADDR_CMODE1);
  assign wr_status  = wr && (addr == `WDT_ADDR_STATUS);
  assign wr_mask    = wr && (addr == `WDT_ADDR_MASK);

  assign option_value = option_erased ? `WDT_OPTION_ERASED : option_byte_in;

  assign refresh_ok = wr_refresh && (wdata == `WDT_REFRESH_SECOND) && refresh_armed_ff;

  assign prot_set = wr_protect && wdata[`WDT_BIT_PROT_EN] && prot_zero_seen_ff &&
                    !protection_enable_ff;

  assign use_sub = source_select_ff && !protection_enable_ff;

  assign cpu_tick = prescale_ff == (prescale_select_ff ? `WDT_DIV_CPU_HI : `WDT_DIV_CPU_LO);

  assign sub_tick = sub_edge && (subdiv_ff == `WDT_DIV_SUB);

  assign count_en  = run_ff && !halted && boot_done_ff;
  assign underflow = count_en && count_tick && (count_ff == 15'h0000);

  always @* begin
    if (protection_enable_ff) begin
      init_value = `WDT_INIT_PROT;
      count_tick = losc_edge;
    end else if (use_sub) begin
      init_value = (`WDT_INIT_SUB_BASE << initial_count_select_ff) - 15'h0001;
      count_tick = sub_tick;
    end else begin
      init_value = `WDT_INIT_CPU;
      count_tick = cpu_tick;
    end
  end

  always @* begin
    if (protection_enable_ff) begin
      halted = 1'b0;
    end else if (use_sub) begin
      halted = cpu_stop_mode;
    end else begin
      halted = cpu_stop_mode || cpu_wait_mode;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      prescale_ff <= 7'h00;
      subdiv_ff   <= 5'h00;
    end else if (!run_ff || halted || !boot_done_ff) begin
      prescale_ff <= prescale_ff;
      subdiv_ff   <= subdiv_ff;
    end else begin
      if (cpu_tick) begin
        prescale_ff <= 7'h00;
      end else begin
        prescale_ff <= prescale_ff + 7'h01;
      end
      if (sub_edge) begin
        subdiv_ff <= subdiv_ff + 5'h01;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      boot_done_ff <= 1'b0;
      option_ff    <= `WDT_OPTION_ERASED;
      run_ff       <= 1'b0;
    end else if (!boot_done_ff) begin
      boot_done_ff <= 1'b1;
      option_ff    <= option_value;
      run_ff       <= ~option_value[`WDT_BIT_AUTO_DIS];
    end else if (wr_start) begin
      run_ff <= 1'b1;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      protection_enable_ff      <= 1'b0;
      prot_zero_seen_ff         <= 1'b0;
      source_select_ff          <= 1'b0;
      initial_count_select_ff   <= 2'b00;
      underflow_reset_select_ff <= 1'b0;
      lowspeed_osc_stop_ff      <= 1'b0;
      stop_mode_request_ff      <= 1'b0;
      prescale_select_ff        <= 1'b0;
    end else if (!boot_done_ff) begin
      if (!option_value[`WDT_BIT_PROT_INIT]) begin
        protection_enable_ff      <= 1'b1;
        underflow_reset_select_ff <= 1'b1;
        lowspeed_osc_stop_ff      <= 1'b0;
      end
    end else begin
      if (wr_control) begin
        prescale_select_ff <= wdata[`WDT_BIT_PRESCALE];
      end
      if (wr_protect) begin
        prot_zero_seen_ff       <= ~wdata[`WDT_BIT_PROT_EN];
        source_select_ff        <= wdata[`WDT_BIT_SRC_SEL];
        initial_count_select_ff <= {wdata[`WDT_BIT_ICS_HI], wdata[`WDT_BIT_ICS_LO]};
      end
      if (prot_set) begin
        protection_enable_ff      <= 1'b1;
        underflow_reset_select_ff <= 1'b1;
        lowspeed_osc_stop_ff      <= 1'b0;
      end else if (wr_pmode1 && !protection_enable_ff) begin
        underflow_reset_select_ff <= wdata[`WDT_BIT_URS];
      end
      if (wr_cmode1 && !protection_enable_ff && !prot_set) begin
        lowspeed_osc_stop_ff <= wdata[`WDT_BIT_LOSC_STOP];
        stop_mode_request_ff <= wdata[`WDT_BIT_STOP_REQ];
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      refresh_armed_ff <= 1'b0;
    end else if (wr_refresh) begin
      refresh_armed_ff <= (wdata == `WDT_REFRESH_FIRST);
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      count_ff <= `WDT_INIT_CPU;
    end else if (!boot_done_ff) begin
      if (!option_value[`WDT_BIT_PROT_INIT]) begin
        count_ff <= `WDT_INIT_PROT;
      end else begin
        count_ff <= `WDT_INIT_CPU;
      end
    end else if (prot_set) begin
      count_ff <= `WDT_INIT_PROT;
    end else if (refresh_ok) begin
      count_ff <= init_value;
    end else if (underflow) begin
      count_ff <= init_value;
    end else if (count_en && count_tick) begin
      count_ff <= count_ff - 15'h0001;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wdt_reset_ff <= 1'b0;
      status_ff    <= 1'b0;
      mask_ff      <= 1'b0;
    end else begin
      wdt_reset_ff <= underflow && (protection_enable_ff || underflow_reset_select_ff);
      if (underflow && !protection_enable_ff && !underflow_reset_select_ff) begin
        status_ff <= 1'b1;
      end else if (wr_status && wdata[`WDT_BIT_UNDERFLOW]) begin
        status_ff <= 1'b0;
      end
      if (wr_mask) begin
        mask_ff <= wdata[`WDT_BIT_UNDERFLOW];
      end
    end
  end

  always @* begin
    nxt_rdata = 16'h0000;
    case (addr)
      `WDT_ADDR_CONTROL: begin
        nxt_rdata[`WDT_BIT_PRESCALE] = prescale_select_ff;
        nxt_rdata[4:0] = count_ff[14:10];
      end
      `WDT_ADDR_PROTECT: begin
        nxt_rdata[`WDT_BIT_PROT_EN] = protection_enable_ff;
        nxt_rdata[`WDT_BIT_SRC_SEL] = source_select_ff;
        nxt_rdata[`WDT_BIT_ICS_HI]  = initial_count_select_ff[1];
        nxt_rdata[`WDT_BIT_ICS_LO]  = initial_count_select_ff[0];
      end
      `WDT_ADDR_PMODE1: begin
        nxt_rdata[`WDT_BIT_URS] = underflow_reset_select_ff;
      end
      `WDT_ADDR_CMODE1: begin
        nxt_rdata[`WDT_BIT_LOSC_STOP] = lowspeed_osc_stop_ff;
        nxt_rdata[`WDT_BIT_STOP_REQ]  = stop_mode_request_ff;
      end
      `WDT_ADDR_STATUS: begin
        nxt_rdata[`WDT_BIT_UNDERFLOW] = status_ff;
      end
      `WDT_ADDR_MASK: begin
        nxt_rdata[`WDT_BIT_UNDERFLOW] = mask_ff;
      end
      `WDT_ADDR_COUNT: begin
        nxt_rdata = {1'b0, count_ff};
      end
      `WDT_ADDR_OPTION: begin
        nxt_rdata = {8'h00, option_ff};
      end
      default: begin
        nxt_rdata = 16'h0000;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 16'h0000;
    end else if (rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  assign rdata             = rdata_ff;
  assign stop_mode_request = stop_mode_request_ff;
  assign lowspeed_osc_stop = lowspeed_osc_stop_ff;
  assign wdt_irq           = status_ff & mask_ff;
  assign wdt_reset         = wdt_reset_ff;
endmodule // watchdog_with_clock_protect

// *** wdt_regs.vh ***
// Register map, field positions, reset values and counts of the watchdog
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

`define WDT_ADDR_REFRESH    16'h0000
`define WDT_ADDR_START      16'h0001
`define WDT_ADDR_CONTROL    16'h0002
`define WDT_ADDR_PROTECT    16'h0003
`define WDT_ADDR_PMODE1     16'h0004
`define WDT_ADDR_CMODE1     16'h0005
`define WDT_ADDR_STATUS     16'h0006
`define WDT_ADDR_MASK       16'h0007
`define WDT_ADDR_COUNT      16'h0008
`define WDT_ADDR_OPTION     16'hFFFF

`define WDT_REFRESH_FIRST   8'h00
`define WDT_REFRESH_SECOND  8'hFF
`define WDT_OPTION_ERASED   8'hFF

`define WDT_BIT_PRESCALE    7
`define WDT_BIT_PROT_EN     7
`define WDT_BIT_SRC_SEL     4
`define WDT_BIT_ICS_HI      1
`define WDT_BIT_ICS_LO      0
`define WDT_BIT_URS         2
`define WDT_BIT_LOSC_STOP   4
`define WDT_BIT_STOP_REQ    0
`define WDT_BIT_AUTO_DIS    0
`define WDT_BIT_PROT_INIT   7
`define WDT_BIT_UNDERFLOW   0

`define WDT_PROTECT_FORCED  8'h80
`define WDT_INIT_CPU        15'h7FFF
`define WDT_INIT_PROT       15'h0FFF
`define WDT_INIT_SUB_BASE   15'h0200
`define WDT_DIV_CPU_LO      7'h0F
`define WDT_DIV_CPU_HI      7'h7F
`define WDT_DIV_SUB         5'h1F

`endif

// *** tick_sync.v ***
// Two-stage synchroniser with rising-edge pulse for an outside clock
`timescale 1ns/10ps
module tick_sync (
  input  wire clk,
  input  wire rst,
  input  wire async_in,
  output wire tick
);
  reg sync1_ff;
  reg sync2_ff;
  reg prev_ff;
  reg tick_ff;

  always @(posedge clk) begin
    if (rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff  <= 1'b0;
      tick_ff  <= 1'b0;
    end else begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
      tick_ff  <= sync2_ff & ~prev_ff;
    end
  end

  assign tick = tick_ff;
endmodule // tick_sync

// *** wdt_properties.sv ***
// Port checker for the watchdog
`timescale 1ns/10ps
`include "wdt_regs.vh"
module wdt_properties (
  input wire        clk,
  input wire        rst,
  input wire [15:0] addr,
  input wire [7:0]  wdata,
  input wire        wr,
  input wire        rd,
  input wire [15:0] rdata,
  input wire        stop_mode_request,
  input wire        lowspeed_osc_stop,
  input wire        wdt_irq,
  input wire        wdt_reset
);
  reg  zero_ff;
  reg  prot_ff;
  wire pw = wr && addr == `WDT_ADDR_PROTECT;
  wire rc = rd && addr == `WDT_ADDR_COUNT;
  // Track zero-then-one protection writes
  always @(posedge clk) begin
    if (rst) begin
      zero_ff <= 1'b0;
      prot_ff <= 1'b0;
    end else if (pw) begin
      zero_ff <= !wdata[7];
      if (zero_ff && wdata[7])
        prot_ff <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside answer cycle");
  reset_pulse_a: assert property (wdt_reset |=> !wdt_reset)
    else $error("reset pulse longer than one cycle");
  count_width_a: assert property (rc |=> rdata[15] == 1'b0)
    else $error("count wider than 15 bits");
  osc_on_a: assert property (prot_ff |-> !lowspeed_osc_stop)
    else $error("oscillator stop set under protection");
  stop_block_a: assert property (prot_ff |-> !$rose(stop_mode_request))
    else $error("stop request rose under protection");
  prot_sticky_a: assert property (prot_ff && rd && addr == `WDT_ADDR_PROTECT |=> rdata[7])
    else $error("protection bit cleared");
  urs_set_a: assert property (prot_ff && rd && addr == `WDT_ADDR_PMODE1 |=> rdata[2])
    else $error("reset select not set under protection");
  prot_count_a: assert property (prot_ff && rc |=> rdata <= 16'h0FFF)
    else $error("count above 0FFF under protection");
  mask_gate_a: assert property (wr && addr == `WDT_ADDR_MASK && !wdata[0] |=> !wdt_irq)
    else $error("interrupt high while masked");
endmodule // wdt_properties

bind watchdog_with_clock_protect wdt_properties chk_i (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stop_mode_request(stop_mode_request),
  .lowspeed_osc_stop(lowspeed_osc_stop), .wdt_irq(wdt_irq), .wdt_reset(wdt_reset));

// *** watchdog_with_clock_protect_tb_top.sv ***
// Self-checking bench for the watchdog
`timescale 1ns/10ps
`include "wdt_regs.vh"
module watchdog_with_clock_protect_tb_top;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [15:0] addr = 16'h0000;
  reg  [7:0]  wdata = 8'h00;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg  [7:0]  opt = 8'h00;
  reg         ers = 1'b1;
  reg         sub = 1'b0;
  reg         osc = 1'b0;
  reg         sub_on = 1'b0;
  reg         osc_on = 1'b0;
  reg         stp = 1'b0;
  reg         wt = 1'b0;
  reg         rd_d = 1'b0;
  wire [15:0] rdata;
  wire        sreq;
  wire        ostp;
  wire        irq;
  wire        wrst;
  reg  [15:0] exp_q[$];
  reg  [15:0] tol_q[$];
  integer     error_cnt = 0;
  integer     checks_done = 0;
  integer     cyc = 0;
  integer     rst_cnt = 0;
  integer     seed = 32'h91c5_2832;
  integer     i;
  reg  [31:0] rv;

  watchdog_with_clock_protect watchdog_with_clock_protect_i (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .option_byte_in(opt),
    .option_erased(ers), .subclock_input(sub), .lowspeed_osc_clk(osc), .cpu_stop_mode(stp),
    .cpu_wait_mode(wt), .stop_mode_request(sreq), .lowspeed_osc_stop(ostp), .wdt_irq(irq),
    .wdt_reset(wrst));

  always #4 clk = ~clk;
  always #16 if (sub_on) sub = ~sub;
  always #16 if (osc_on) osc = ~osc;

  task test_done;
    begin
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  // Pass when g lies in e-t .. e
  task chk(input [15:0] g, input [15:0] e, input [15:0] t);
    begin
      checks_done++;
      if ((g <= e && g + t >= e) !== 1'b1) begin
        error_cnt++;
        $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
    end
  endtask

  task wreg(input [15:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
    end
  endtask

  task rreg(input [15:0] a, input [15:0] e, input [15:0] t);
    begin
      exp_q.push_back(e);
      tol_q.push_back(t);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
    end
  endtask

  task refresh;
    begin
      wreg(`WDT_ADDR_REFRESH, 8'h00);
      wreg(`WDT_ADDR_REFRESH, 8'hFF);
    end
  endtask

  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d)
      chk(rdata, exp_q.pop_front(), tol_q.pop_front());
    if (wrst === 1'b1)
      rst_cnt++;
    cyc++;
    if (cyc == 99000) begin
      error_cnt++;
      test_done;
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rreg(`WDT_ADDR_OPTION, 16'h00FF, 0);
    rreg(`WDT_ADDR_PROTECT, 16'h0000, 0);
    repeat (40) @(posedge clk);
    rreg(`WDT_ADDR_COUNT, 16'h7FFF, 0);
    wt <= 1'b1;
    wreg(`WDT_ADDR_START, 8'h00);
    repeat (200) @(posedge clk);
    rreg(`WDT_ADDR_COUNT, 16'h7FFF, 0);
    wt <= 1'b0;
    repeat (160) @(posedge clk);
    rreg(`WDT_ADDR_COUNT, 16'h7FF6, 2);
    rv = $random(seed);
    wreg(`WDT_ADDR_REFRESH, (rv[7:0] & 8'h7E) | 8'h01);
    wreg(`WDT_ADDR_REFRESH, 8'hFF);
    rreg(`WDT_ADDR_COUNT, 16'h7FF6, 3);
    wreg(`WDT_ADDR_CONTROL, 8'h80);
    refresh;
    repeat (256) @(posedge clk);
    rreg(`WDT_ADDR_COUNT, 16'h7FFE, 2);
    wreg(`WDT_ADDR_PROTECT, 8'h03);
    refresh;
    rreg(`WDT_ADDR_COUNT, 16'h7FFF, 1);
    for (i = 3; i >= 0; i--) begin
      wreg(`WDT_ADDR_PROTECT, 8'h10 | i[7:0]);
      refresh;
      rreg(`WDT_ADDR_COUNT, (16'h0200 << i) - 16'h0001, 0);
    end
    wreg(`WDT_ADDR_MASK, 8'h01);
    wt     <= 1'b1;
    sub_on <= 1'b1;
    for (i = 0; i < 70000 && irq !== 1'b1; i++)
      @(posedge clk);
    sub_on <= 1'b0;
    wt     <= 1'b0;
    chk({15'h0000, irq}, 16'h0001, 0);
    chk(rst_cnt[15:0], 16'h0000, 0);
    rreg(`WDT_ADDR_STATUS, 16'h0001, 0);
    wreg(`WDT_ADDR_MASK, 8'h00);
    wreg(`WDT_ADDR_MASK, 8'h01);
    wreg(`WDT_ADDR_STATUS, 8'h01);
    rreg(`WDT_ADDR_STATUS, 16'h0000, 0);
    wreg(`WDT_ADDR_CMODE1, 8'h10);
    wreg(`WDT_ADDR_PROTECT, 8'h00);
    wreg(`WDT_ADDR_PROTECT, 8'h80);
    rreg(`WDT_ADDR_COUNT, 16'h0FFF, 0);
    rreg(`WDT_ADDR_PMODE1, 16'h0004, 0);
    wreg(`WDT_ADDR_CMODE1, 8'h11);
    rreg(`WDT_ADDR_CMODE1, 16'h0000, 0);
    wreg(`WDT_ADDR_PROTECT, 8'h00);
    rreg(`WDT_ADDR_PROTECT, 16'h0080, 0);
    chk({14'h0000, sreq, ostp}, 16'h0000, 0);
    wt     <= 1'b1;
    stp    <= 1'b1;
    osc_on <= 1'b1;
    for (i = 0; i < 20000 && wrst !== 1'b1; i++)
      @(posedge clk);
    chk({15'h0000, wrst}, 16'h0001, 0);
    chk({15'h0000, irq}, 16'h0000, 0);
    opt <= 8'h7E;
    ers <= 1'b0;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rreg(`WDT_ADDR_PROTECT, 16'h0080, 0);
    rreg(`WDT_ADDR_COUNT, 16'h0FFF, 4);
    wreg(`WDT_ADDR_OPTION, 8'h00);
    rreg(`WDT_ADDR_OPTION, 16'h007E, 0);
    osc_on <= 1'b0;
    repeat (4) @(posedge clk);
    test_done;
  end
endmodule // watchdog_with_clock_protect_tb_top
